// ==== hw/rsw_top.sv ====
// Reset sources, start-up delay and watchdog with AXI4-Lite registers
// Contract
// - Four reset sources reset the device
// - Power-on reset immediate; rise starts delay
// - Long external pin low resets, clockless
// - Pin release waits start-up time-out
// - Brown-out resets immediately, releases after time-out
// - Brown-out ignores dips shorter than filter
// - Watchdog reset pulse one clock; delay follows
// - Bandgap on for brown-out, comparator, converter
// - Watchdog counts separate 128 kHz oscillator
// - Counter cleared by restart, disable, reset
// - Ten selectable time-out periods
// - Expiry with reset action resets device
// - Time-out may raise interrupt instead
// - Level 1 starts disabled, enable anytime
// - Disable or period change inside window
// - Level 2 always running, enable reads one
// - Level 2 period change by timed sequence
// - Change window closes four clocks later
// - First time-out interrupts, clears interrupt enable, next resets
// - Level 1 enable forced while reset flag set
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module rsw_top #(
   parameter int STARTUP_CYC  = rsw_pkg::STARTUP_CYCLES,
   parameter int BOD_FILT_CYC = rsw_pkg::BOD_FILTER_CYCLES,
   parameter int DLY_W        = 24
) (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        supply_below_por,
   input  wire logic        reset_pin_n,
   input  wire logic        reset_pin_enable,
   input  wire logic        supply_below_bod,
   input  wire logic [2:0]  brownout_level_fuses,
   input  wire logic        safety_level_fuse,
   input  wire logic        wdt_osc_clk,
   input  wire logic        irq_vector_ack,
   output logic             device_reset,
   output logic             bandgap_enable,
   output logic             wdt_irq,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   localparam logic [DLY_W-1:0] DLY_LAST  = DLY_W'(STARTUP_CYC - 1);
   localparam logic [15:0]      BOD_LAST  = 16'(BOD_FILT_CYC);

   // Register index match for a byte address
   function automatic logic idx_hit(input logic [11:0] a,
                                    input logic [9:0] idx);
      idx_hit = (a[11:2] == idx);
   endfunction

   // Straps, bus and internal state
   logic             level2_q;
   logic [2:0]       bod_fuse_q;
   logic             aw_hold_q;
   logic             w_hold_q;
   logic [11:0]      awaddr_q;
   logic [31:0]      wdata_q;
   logic [3:0]       wstrb_q;
   logic             rst_q;
   logic [DLY_W-1:0] dly_q;
   logic [15:0]      bod_cnt_q;
   logic             bod_trip_q;
   logic             wdt_pulse_q;
   logic             osc_s1_q;
   logic             osc_s2_q;
   logic             osc_s3_q;
   logic [20:0]      wdt_cnt_q;
   logic [2:0]       win_q;
   logic [3:0]       stat_q;
   logic [1:0]       misc_q;
   rsw_pkg::rsw_ctrl_t ctrl_q;

   // Write decode
   wire        we       = aw_hold_q & w_hold_q & ~s_axi_bvalid;
   wire        wr_lane  = we & wstrb_q[0];
   wire [7:0]  wd       = wdata_q[7:0];
   wire        wr_ctrl  = wr_lane & idx_hit(awaddr_q, rsw_pkg::CTRL_IDX);
   wire        wr_stat  = wr_lane & idx_hit(awaddr_q, rsw_pkg::STATUS_IDX);
   wire        wr_misc  = wr_lane & idx_hit(awaddr_q, rsw_pkg::MISC_IDX);
   wire        wr_rstrt = wr_lane & idx_hit(awaddr_q, rsw_pkg::RESTART_IDX);
   wire        w_mapped = idx_hit(awaddr_q, rsw_pkg::CTRL_IDX)
                        | idx_hit(awaddr_q, rsw_pkg::STATUS_IDX)
                        | idx_hit(awaddr_q, rsw_pkg::MISC_IDX)
                        | idx_hit(awaddr_q, rsw_pkg::RESTART_IDX);

   // Reset sources
   wire bod_on    = (bod_fuse_q != rsw_pkg::BOD_FUSE_OFF);
   wire ext_low   = reset_pin_enable & ~reset_pin_n;
   wire async_src = supply_below_por | ext_low;
   wire sync_src  = srst | bod_trip_q | wdt_pulse_q;

   // Watchdog control decode
   wire watchdog_reset_flag      = stat_q[rsw_pkg::STAT_WATCHDOG_RESET_FLAG_BIT];
   wire en_eff    = level2_q | ctrl_q.en | watchdog_reset_flag;
   wire run       = en_eff | ctrl_q.ie;
   wire in_win    = (win_q != 3'h0);
   wire open_seq  = wr_ctrl & wd[rsw_pkg::CTRL_CE_BIT]
                  & wd[rsw_pkg::CTRL_EN_BIT];
   wire change    = wr_ctrl & in_win & ~wd[rsw_pkg::CTRL_CE_BIT];
   wire restart   = wr_rstrt & wd[rsw_pkg::RESTART_BIT];
   wire osc_tick  = osc_s2_q & ~osc_s3_q;
   wire [20:0] per_last = rsw_pkg::rsw_period(ctrl_q.per) - 21'h1;
   wire timeout   = run & osc_tick & ~restart & (wdt_cnt_q >= per_last);
   wire irq_fire  = timeout & ctrl_q.ie;
   wire rst_fire  = timeout & ~ctrl_q.ie & en_eff;
   wire ie_hw_clr = irq_fire & en_eff;

   // Read data and response
   wire [7:0] ctrl_rd = {ctrl_q.flag, ctrl_q.ie, ctrl_q.per[3], in_win,
                         en_eff, ctrl_q.per[2:0]};
   wire r_ctrl = idx_hit(s_axi_araddr, rsw_pkg::CTRL_IDX);
   wire r_stat = idx_hit(s_axi_araddr, rsw_pkg::STATUS_IDX);
   wire r_misc = idx_hit(s_axi_araddr, rsw_pkg::MISC_IDX);
   wire r_rst  = idx_hit(s_axi_araddr, rsw_pkg::RESTART_IDX);
   wire [31:0] rd_mux = r_ctrl ? {24'h00_0000, ctrl_rd}
                      : r_stat ? {28'h000_0000, stat_q}
                      : r_misc ? {30'h0000_0000, misc_q}
                      : 32'h0000_0000;
   wire [1:0] rd_resp = (r_ctrl | r_stat | r_misc | r_rst)
                      ? rsw_pkg::RESP_OKAY : rsw_pkg::RESP_SLVERR;

   // Straps are caught while the block reset is held
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         level2_q   <= safety_level_fuse;
         bod_fuse_q <= brownout_level_fuses;
      end
   end

   // Write address and data taken in either order
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         aw_hold_q     <= 1'b0;
         s_axi_awready <= 1'b1;
         awaddr_q      <= 12'h000;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_hold_q     <= 1'b1;
         s_axi_awready <= 1'b0;
         awaddr_q      <= s_axi_awaddr;
      end
      else if (we)
         aw_hold_q <= 1'b0;
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_awready <= 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         w_hold_q     <= 1'b0;
         s_axi_wready <= 1'b1;
         wdata_q      <= 32'h0000_0000;
         wstrb_q      <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_hold_q     <= 1'b1;
         s_axi_wready <= 1'b0;
         wdata_q      <= s_axi_wdata;
         wstrb_q      <= s_axi_wstrb;
      end
      else if (we)
         w_hold_q <= 1'b0;
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_wready <= 1'b1;
   end

   // Write response one cycle after both halves are held
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= rsw_pkg::RESP_OKAY;
      end
      else if (we)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= w_mapped ? rsw_pkg::RESP_OKAY
                                  : rsw_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Read channel, answered the cycle after the address
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= rsw_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= rd_resp;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Brown-out filter; short dips never reach the counter's end
   always_ff @(posedge clk_sys)
   begin
      if (srst || !bod_on || !supply_below_bod)
      begin
         bod_cnt_q  <= 16'h0000;
         bod_trip_q <= 1'b0;
      end
      else if (bod_cnt_q == BOD_LAST)
         bod_trip_q <= 1'b1;
      else
         bod_cnt_q <= bod_cnt_q + 16'h0001;
   end

   // Internal reset: pin and supply set it with no clock needed,
   // release only after the start-up count, on a clock edge
   always_ff @(posedge clk_sys or posedge async_src)
   begin
      if (async_src)
      begin
         rst_q <= 1'b1;
         dly_q <= '0;
      end
      else if (sync_src)
      begin
         rst_q <= 1'b1;
         dly_q <= '0;
      end
      else if (rst_q)
      begin
         if (dly_q == DLY_LAST)
            rst_q <= 1'b0;
         else
            dly_q <= dly_q + DLY_W'(1);
      end
   end

   // One-clock watchdog reset pulse; the delay starts after it falls
   always_ff @(posedge clk_sys)
   begin
      if (srst || rst_q)
         wdt_pulse_q <= 1'b0;
      else
         wdt_pulse_q <= rst_fire;
   end

   // Oscillator synchroniser; only the later stages feed the edge
   always_ff @(posedge clk_sys)
   begin
      osc_s1_q <= wdt_osc_clk;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
   end

   // Watchdog counter in oscillator cycles
   always_ff @(posedge clk_sys)
   begin
      if (srst || rst_q || restart || !run)
         wdt_cnt_q <= 21'h0_0000;
      else if (osc_tick)
         wdt_cnt_q <= (wdt_cnt_q >= per_last) ? 21'h0_0000
                                               : wdt_cnt_q + 21'h1;
   end

   // Change window; reopened by a fresh opening write
   always_ff @(posedge clk_sys)
   begin
      if (srst || rst_q)
         win_q <= 3'h0;
      else if (open_seq)
         win_q <= rsw_pkg::CHANGE_WINDOW_CYC;
      else if (change)
         win_q <= 3'h0;
      else if (in_win)
         win_q <= win_q - 3'h1;
   end

   // Watchdog control; level 1 starts stopped after device reset unless watchdog_reset_flag is set
   always_ff @(posedge clk_sys)
   begin
      if (srst || rst_q)
      begin
         ctrl_q.en   <= 1'b0;
         ctrl_q.ie   <= 1'b0;
         ctrl_q.per  <= rsw_pkg::PER_RST;
         ctrl_q.flag <= 1'b0;
      end
      else
      begin
         if (wr_ctrl && wd[rsw_pkg::CTRL_EN_BIT])
            ctrl_q.en <= 1'b1;
         else if (change && !level2_q)
            ctrl_q.en <= 1'b0;
         if (change)
            ctrl_q.per <= {wd[rsw_pkg::CTRL_P3_BIT], wd[2:0]};
         // Hardware clear wins so reset security is never lost
         if (ie_hw_clr)
            ctrl_q.ie <= 1'b0;
         else if (wr_ctrl)
            ctrl_q.ie <= wd[rsw_pkg::CTRL_IE_BIT];
         // Time-out flag: set wins over any clear
         if (irq_fire)
            ctrl_q.flag <= 1'b1;
         else if (irq_vector_ack ||
                  (wr_ctrl && wd[rsw_pkg::CTRL_FLAG_BIT]))
            ctrl_q.flag <= 1'b0;
      end
   end

   // Reset cause flags survive the internal reset; set beats clear
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         stat_q <= rsw_pkg::STAT_RST;
      else if (supply_below_por)
         stat_q <= 4'h1;
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (wr_stat && !wd[i])
               stat_q[i] <= 1'b0;
         end
         if (ext_low)
            stat_q[rsw_pkg::STAT_EXTRF_BIT] <= 1'b1;
         if (bod_trip_q)
            stat_q[rsw_pkg::STAT_BORF_BIT] <= 1'b1;
         if (wdt_pulse_q)
            stat_q[rsw_pkg::STAT_WATCHDOG_RESET_FLAG_BIT] <= 1'b1;
      end
   end

   // Comparator and converter reference requests
   always_ff @(posedge clk_sys)
   begin
      if (srst || rst_q)
         misc_q <= 2'h0;
      else if (wr_misc)
         misc_q <= wd[1:0];
   end

   // Bandgap enable, registered
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         bandgap_enable <= 1'b0;
      else
         bandgap_enable <= bod_on | misc_q[rsw_pkg::MISC_COMPARATOR_BANDGAP_SELECT_BIT]
                         | misc_q[rsw_pkg::MISC_ADCEN_BIT];
   end

   // Outputs straight from flops
   assign device_reset = rst_q;
   assign wdt_irq      = ctrl_q.flag;

endmodule // rsw_top

// ==== pkg/rsw_pkg.sv ====
// Constants, field layout and types for the reset and watchdog block
package rsw_pkg;
   // Timing
   localparam int CLK_PERIOD_NS      = 8;
   localparam int STARTUP_TIMEOUT_NS = 64_000_000;
   localparam int STARTUP_CYCLES     = STARTUP_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int BOD_FILTER_NS      = 2_000;
   localparam int BOD_FILTER_CYCLES  =
      (BOD_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WDT_OSC_HZ         = 128_000;
   localparam int WDT_BASE_CYCLES    = 2048;
   localparam logic [2:0] CHANGE_WINDOW_CYC = 3'h4;
   localparam logic [3:0] WDT_LAST_CODE     = 4'h9;
   localparam logic [3:0] WDT_FALLBACK_CODE = 4'h9;
   // Register indices; byte address is four times the index
   localparam logic [9:0] CTRL_IDX    = 10'h021;
   localparam logic [9:0] STATUS_IDX  = 10'h022;
   localparam logic [9:0] RESTART_IDX = 10'h023;
   localparam logic [9:0] MISC_IDX    = 10'h024;
   // Control register fields
   localparam int CTRL_FLAG_BIT = 7;
   localparam int CTRL_IE_BIT   = 6;
   localparam int CTRL_P3_BIT   = 5;
   localparam int CTRL_CE_BIT   = 4;
   localparam int CTRL_EN_BIT   = 3;
   // Status register fields
   localparam int STAT_WATCHDOG_RESET_FLAG_BIT  = 3;
   localparam int STAT_BORF_BIT  = 2;
   localparam int STAT_EXTRF_BIT = 1;
   localparam int STAT_PORF_BIT  = 0;
   // Restart and misc fields
   localparam int RESTART_BIT = 0;
   localparam int MISC_COMPARATOR_BANDGAP_SELECT_BIT  = 0;
   localparam int MISC_ADCEN_BIT = 1;
   // Reset values and encodings
   localparam logic [3:0] STAT_RST     = 4'h0;
   localparam logic [3:0] PER_RST      = 4'h0;
   localparam logic [2:0] BOD_FUSE_OFF = 3'h7;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   typedef struct packed {
      logic       flag;
      logic       ie;
      logic [3:0] per;
      logic       en;
   } rsw_ctrl_t;

   // Time-out length in oscillator cycles, reserved codes fall back
   function automatic logic [20:0] rsw_period(input logic [3:0] code);
      logic [3:0] c;
      c = (code > WDT_LAST_CODE) ? WDT_FALLBACK_CODE : code;
      rsw_period = 21'(WDT_BASE_CYCLES) << c;
   endfunction
endpackage

// ==== sim/rsw_chk_asserts.sv ====
// Port-level assertions for the reset and watchdog block
`timescale 1ns/1ps
module rsw_chk #(
   parameter int STARTUP_CYC = 16
) (
   input wire logic        clk_sys,
   input wire logic        srst,
   input wire logic        supply_below_por,
   input wire logic        reset_pin_n,
   input wire logic        reset_pin_enable,
   input wire logic        supply_below_bod,
   input wire logic [2:0]  brownout_level_fuses,
   input wire logic        safety_level_fuse,
   input wire logic        irq_vector_ack,
   input wire logic        device_reset,
   input wire logic        bandgap_enable,
   input wire logic        wdt_irq,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata
);
   logic [23:0] quiet_q;
   logic [23:0] quiet_d;
   wire         src_on;
   // Cycles since the last async source, saturating so it never wraps
   assign src_on = supply_below_por || (reset_pin_enable && !reset_pin_n);
   assign quiet_d = (&quiet_q) ? quiet_q : quiet_q + 24'h00_0001;
   always_ff @(posedge clk_sys)
   begin
      if (srst || src_on)
         quiet_q <= '0;
      else
         quiet_q <= quiet_d;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   // Control register read request in safety level 2
   sequence s_lvl2_ctrl_ar;
      safety_level_fuse ##0
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h084);
   endsequence
   property p_por; supply_below_por |-> device_reset; endproperty
   property p_pin; reset_pin_enable && !reset_pin_n |-> device_reset;
   endproperty
   property p_startup;
      $fell(device_reset) |-> quiet_q >= 24'(STARTUP_CYC - 1);
   endproperty
   // Filter of four cycles in the bench build, so six is past it
   property p_bod;
      (brownout_level_fuses != 3'h7 && supply_below_bod) [*6]
      |=> device_reset;
   endproperty
   property p_bg; brownout_level_fuses != 3'h7 |-> ##2 bandgap_enable;
   endproperty
   property p_irq;
      wdt_irq && !irq_vector_ack && !s_axi_wvalid && !device_reset
      |=> wdt_irq;
   endproperty
   property p_lvl2; s_lvl2_ctrl_ar |=> s_axi_rvalid && s_axi_rdata[3];
   endproperty
   property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_por: assert property (p_por)
      else $error("device reset low under power-on");
   a_pin: assert property (p_pin)
      else $error("device reset low while pin held low");
   a_startup: assert property (p_startup)
      else $error("device reset released before start-up delay");
   a_bod: assert property (p_bod)
      else $error("long brown-out gave no reset");
   a_bg: assert property (p_bg)
      else $error("reference off with brown-out enabled");
   a_irq: assert property (p_irq)
      else $error("time-out flag dropped without clear");
   a_lvl2: assert property (p_lvl2)
      else $error("enable reads zero in level 2");
   a_rd: assert property (p_rd)
      else $error("read answer late");
endmodule // rsw_chk

bind rsw_top rsw_chk #(.STARTUP_CYC(STARTUP_CYC)) u_chk (
   .clk_sys(clk_sys), .srst(srst), .supply_below_por(supply_below_por),
   .reset_pin_n(reset_pin_n), .reset_pin_enable(reset_pin_enable),
   .supply_below_bod(supply_below_bod), .irq_vector_ack(irq_vector_ack),
   .brownout_level_fuses(brownout_level_fuses),
   .safety_level_fuse(safety_level_fuse), .device_reset(device_reset),
   .bandgap_enable(bandgap_enable), .wdt_irq(wdt_irq),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata));

// ==== sim/rsw_core_bfm.sv ====
// Core-side bus master issuing register writes and reads
`timescale 1ns/1ps
module rsw_core_bfm (
   input  wire logic        clk_sys,
   output logic [11:0]      awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic        bvalid,
   output logic [11:0]      araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid
);
   // Idle bus; released payload is inverted so stale data never helps
   initial
   begin
      awaddr = '0;
      awvalid = 1'b0;
      wdata = '0;
      wvalid = 1'b0;
      araddr = '0;
      arvalid = 1'b0;
   end
   // Write: both channels offered, each dropped at its own handshake
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic pa;
      logic pw;
      pa = 1'b1;
      pw = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (pa || pw || !bvalid)
      begin
         @(posedge clk_sys);
         if (pa && awready)
         begin
            awvalid <= 1'b0;
            awaddr <= ~a;
            pa = 1'b0;
         end
         if (pw && wready)
         begin
            wvalid <= 1'b0;
            wdata <= ~d;
            pw = 1'b0;
         end
      end
   endtask
   // Read: address held until taken, data kept at the answer edge
   task automatic rd(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (arvalid && arready)
         begin
            arvalid <= 1'b0;
            araddr <= ~a;
         end
      end
      while (!rvalid);
      d = rdata;
      r = rresp;
   endtask
endmodule // rsw_core_bfm

// ==== sim/tb.sv ====
// Self-checking bench for the reset and watchdog block
`timescale 1ns/1ps
module tb;
   localparam logic [11:0] A_CTRL = {rsw_pkg::CTRL_IDX, 2'b00};
   localparam logic [11:0] A_STAT = {rsw_pkg::STATUS_IDX, 2'b00};
   localparam logic [11:0] A_RSTR = {rsw_pkg::RESTART_IDX, 2'b00};
   localparam logic [11:0] A_MISC = {rsw_pkg::MISC_IDX, 2'b00};
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic        por = 1'b1;
   logic        pin_n = 1'b1;
   logic        pin_en = 1'b1;
   logic        brownout_detector = 1'b0;
   logic [2:0]  fuses = 3'h7;
   logic        safe = 1'b0;
   logic        osc = 1'b0;
   logic        osc_run = 1'b0;
   logic        ack = 1'b0;
   logic        dev_rst, bg, irq, awv, awr, wv, wr_r, bv, arv, arr, rv_o;
   logic [11:0] awa, ara;
   logic [31:0] wd, rd_d, rv;
   logic [1:0]  br, rr_o, rr;
   int          miscompares = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          n;
   rsw_top #(.STARTUP_CYC(16), .BOD_FILT_CYC(4)) u_dut (
      .clk_sys(clk_sys), .srst(srst), .supply_below_por(por),
      .reset_pin_n(pin_n), .reset_pin_enable(pin_en),
      .supply_below_bod(brownout_detector), .brownout_level_fuses(fuses),
      .safety_level_fuse(safe), .wdt_osc_clk(osc), .irq_vector_ack(ack),
      .device_reset(dev_rst), .bandgap_enable(bg), .wdt_irq(irq),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr_o),
      .s_axi_rvalid(rv_o), .s_axi_rready(1'b1));
   rsw_core_bfm u_core (
      .clk_sys(clk_sys), .awaddr(awa), .awvalid(awv), .awready(awr),
      .wdata(wd), .wvalid(wv), .wready(wr_r), .bvalid(bv), .araddr(ara),
      .arvalid(arv), .arready(arr), .rdata(rd_d), .rresp(rr_o),
      .rvalid(rv_o));
   always #4 clk_sys = ~clk_sys;
   // Fast oscillator stand-in, four clocks a tick; hang limit
   always @(posedge clk_sys)
   begin
      cyc++;
      if (osc_run && cyc % 2 == 0) osc <= ~osc;
      if (cyc == 60000)
      begin
         miscompares++;
         give_verdict;
      end
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
      num_checks++;
      if (s !== e)
      begin
         miscompares++;
         $display("unexpected %s exp %h seen %h", nm, e, s);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task cy(input int k); repeat (k) @(posedge clk_sys); endtask
   // Wait for device reset to reach a level, bounded
   task wt(input logic v, input int lim);
      n = 0;
      while (dev_rst !== v && n < lim)
      begin
         @(posedge clk_sys);
         n++;
      end
   endtask
   task rdc(input logic [11:0] a); u_core.rd(a, rv, rr); endtask
   task t_boot;
      wt(1'b0, 100);
      chk("boot hold", n >= 15, 1);
      rdc(A_STAT); chk("status", rv, 32'h0000_0001);
      rdc(A_CTRL); chk("ctrl", rv, 32'h0000_0000);
      rdc(12'h0FC); chk("resp", rr, rsw_pkg::RESP_SLVERR);
      chk("rdata", rv, 32'h0000_0000);
      u_core.wr(12'h0FC, 32'h0000_0000);
      chk("bresp", br, rsw_pkg::RESP_SLVERR);
   endtask
   task t_bandgap;
      for (int i = 0; i < 4; i++)
      begin
         u_core.wr(A_MISC, 32'(i));
         chk("bresp ok", br, rsw_pkg::RESP_OKAY);
         cy(2);
         chk("bandgap", bg, i != 0);
      end
      u_core.wr(A_MISC, 32'h0000_0000);
   endtask
   task t_window;
      u_core.wr(A_CTRL, 32'h0000_0008);
      rdc(A_CTRL); chk("enable", rv, 32'h0000_0008);
      u_core.wr(A_CTRL, 32'h0000_0000);
      rdc(A_CTRL); chk("no disable", rv, 32'h0000_0008);
      u_core.wr(A_CTRL, 32'h0000_0018);
      u_core.wr(A_CTRL, 32'h0000_0001);
      rdc(A_CTRL); chk("window", rv, 32'h0000_0001);
      u_core.wr(A_CTRL, 32'h0000_0018);
      cy(8);
      u_core.wr(A_CTRL, 32'h0000_0002);
      rdc(A_CTRL); chk("closed", rv, 32'h0000_0009);
      u_core.wr(A_CTRL, 32'h0000_0018);
      u_core.wr(A_CTRL, 32'h0000_0000);
   endtask
   task t_wdt_reset;
      osc_run <= 1'b1;
      u_core.wr(A_CTRL, 32'h0000_0008);
      cy(6000);
      u_core.wr(A_RSTR, 32'h0000_0001);
      cy(6000);
      chk("restart", dev_rst, 0);
      wt(1'b1, 3000);
      chk("bite", dev_rst, 1);
      chk("period", n > 1900 && n < 2400, 1);
      wt(1'b0, 100);
      rdc(A_STAT); chk("watchdog_reset_flag", rv, 32'h0000_0009);
      rdc(A_CTRL); chk("forced", rv, 32'h0000_0008);
      u_core.wr(A_STAT, 32'h0000_0000);
      rdc(A_CTRL); chk("unforced", rv, 32'h0000_0000);
   endtask
   task t_wdt_irq;
      u_core.wr(A_CTRL, 32'h0000_0048);
      for (n = 0; irq !== 1'b1 && n < 9000; n++) cy(1);
      chk("irq", {irq, dev_rst}, 2'b10);
      rdc(A_CTRL); chk("ie cleared", rv, 32'h0000_0088);
      ack <= 1'b1;
      cy(1);
      ack <= 1'b0;
      cy(2);
      chk("irq ack", irq, 0);
      wt(1'b1, 9000);
      chk("second", dev_rst, 1);
      wt(1'b0, 100);
      u_core.wr(A_STAT, 32'h0000_0000);
      osc_run <= 1'b0;
   endtask
   task t_pin;
      // Pin held low with its reset function off must not reset
      pin_en <= 1'b0;
      pin_n <= 1'b0;
      cy(3);
      chk("pin off", dev_rst, 0);
      pin_n <= 1'b1;
      pin_en <= 1'b1;
      cy(1);
      pin_n <= 1'b0;
      #1;
      chk("pin async", dev_rst, 1);
      cy(3);
      pin_n <= 1'b1;
      wt(1'b0, 100);
      chk("pin hold", n >= 15, 1);
      rdc(A_STAT); chk("extrf", rv, 32'h0000_0002);
   endtask
   task brownout_filter_time_lvl2;
      srst <= 1'b1;
      fuses <= 3'h4;
      safe <= 1'b1;
      cy(4);
      srst <= 1'b0;
      wt(1'b0, 100);
      chk("bandgap bod", bg, 1);
      brownout_detector <= 1'b1;
      cy(3);
      brownout_detector <= 1'b0;
      cy(6);
      chk("dip", dev_rst, 0);
      brownout_detector <= 1'b1;
      cy(10);
      chk("brown-out", dev_rst, 1);
      brownout_detector <= 1'b0;
      wt(1'b0, 100);
      chk("bod hold", n >= 15, 1);
      rdc(A_STAT); chk("borf", rv, 32'h0000_0004);
      u_core.wr(A_CTRL, 32'h0000_0000);
      rdc(A_CTRL); chk("level 2", rv[3], 1);
      u_core.wr(A_CTRL, 32'h0000_0018);
      u_core.wr(A_CTRL, 32'h0000_0003);
      rdc(A_CTRL); chk("l2 period", rv, 32'h0000_000B);
   endtask
   // Main sequence: reset, power-on release, then each scenario
   initial
   begin
      cy(4);
      srst <= 1'b0;
      cy(2);
      por <= 1'b0;
      t_boot;
      t_bandgap;
      t_window;
      t_wdt_reset;
      t_wdt_irq;
      t_pin;
      brownout_filter_time_lvl2;
      give_verdict;
   end
endmodule // tb
